// ---- wdt_pkg.sv ----
`default_nettype none
package wdt_pkg;
  // register map, byte offsets on the plain register port
  localparam logic [1:0] WDT_CTRL_OFS   = 2'h0;
  localparam logic [1:0] RST_FLAGS_OFS  = 2'h1;
  localparam logic [1:0] RST_KEY_OFS    = 2'h2;
  localparam logic [1:0] WDT_STATUS_OFS = 2'h3;

  // watchdog_control fields
  localparam int WDT_KEY_LSB = 3;
  localparam int WDT_KEY_MSB = 7;
  localparam int TSEL_LSB    = 0;
  localparam int TSEL_MSB    = 2;

  localparam logic [4:0] WDT_KEY_OFF = 5'h15;
  localparam logic [4:0] WDT_KEY_ON  = 5'h0a;
  localparam logic [7:0] WDT_CTRL_RST = 8'h53;

  localparam logic [7:0] RST_KEY_A   = 8'h55;
  localparam logic [7:0] RST_KEY_B   = 8'haa;
  localparam logic [7:0] RST_KEY_RST = 8'h55;

  // reset_cause_flags bits
  localparam int FLAG_WDT_KEY = 0;
  localparam int FLAG_LV_KEY   = 1;
  localparam int FLAG_LV_EVENT = 2;
  localparam int FLAG_RST_KEY = 3;
  localparam logic [3:0] RST_FLAGS_RST = 4'h0;

  // status bits
  localparam int STAT_TIMEOUT  = 0;
  localparam int STAT_PWR_DOWN = 1;

  // low-speed oscillator and timing
  localparam int SLOW_OSC_FREQ_KHZ = 32;
  localparam logic [1:0] KEY_FAULT_TICKS = 2'h2;
  localparam int CNT_W = 19;
endpackage : wdt_pkg
`default_nettype wire

// ---- watchdog_and_reset_key_control.sv ----
// Summary of operation
// - Watchdog counts edges of the slow RC oscillator, not the system clock.
// - timeout_select codes 0..7 give 2^8,10,12,14,15,16,17,18 oscillator periods.
// - Enable key 10101B disables, 01010B enables the watchdog.
// - Any other enable key resets the device after 1 to 2 oscillator cycles.
// - Bad enable key reset sets wdt_key_reset_flag; only software clears it (here sys_rst_i clears it too).
// - Enable key powers up enabled; timeout_select powers up as 011.
// - Overflow in normal run resets the device and sets timeout_flag.
// - Overflow in sleep or idle sets timeout_flag, clears only PC and SP.
// - Counter cleared by key reset, clear instruction or sleep entry; software clears in time.
// - Reset key 55h or AAh is idle; any other value resets after 1 to 2 cycles.
// - Reset key register powers up as 55h.
// - Bad reset key reset sets reset_key_flag.
// - Flag register upper four bits read zero; low four are read/write.
// - Power-on reset clears PC and presets ports high as inputs.
// - Sleep entry sets power_down_flag, clears timeout_flag and the counter.
// - Overflow in sleep or idle also wakes the device.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_reset_key_control
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // slow oscillator pin
  input  wire logic       low_speed_rc_osc_i,
  // core events
  input  wire logic       clear_watchdog_i,
  input  wire logic       sleep_entry_i,
  input  wire logic       low_power_i,
  // register port
  input  wire logic [1:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // reset and wake outputs
  output logic            device_reset_o,
  output logic            pc_sp_clear_o,
  output logic            port_preset_o,
  output logic            wakeup_o
);

  logic [7:0]       wdt_ctrl;
  logic [7:0]       rst_key;
  logic [3:0]       rst_flags;
  logic             timeout_flag;
  logic             power_down_flag;
  logic [CNT_W-1:0] wdt_cnt;
  logic [1:0]       fault_cnt;
  logic             osc_s1;
  logic             osc_s2;
  logic             osc_s3;

  // only s2/s3 are looked at; s1 feeds nothing but s2
  always_ff @(posedge mclk_i) begin
    osc_s1 <= low_speed_rc_osc_i;
    osc_s2 <= osc_s1;
    osc_s3 <= osc_s2;
  end

  wire       osc_tick  = osc_s2 & ~osc_s3;
  wire [4:0] wdt_key   = wdt_ctrl[WDT_KEY_MSB:WDT_KEY_LSB];
  wire [2:0] tsel      = wdt_ctrl[TSEL_MSB:TSEL_LSB];

  function automatic logic [4:0] tsel_shift(input logic [2:0] code);
    unique case (code)
      3'h0: tsel_shift = 5'd8;
      3'h1: tsel_shift = 5'd10;
      3'h2: tsel_shift = 5'd12;
      3'h3: tsel_shift = 5'd14;
      3'h4: tsel_shift = 5'd15;
      3'h5: tsel_shift = 5'd16;
      3'h6: tsel_shift = 5'd17;
      3'h7: tsel_shift = 5'd18;
    endcase
  endfunction

  wire wdt_en       = (wdt_key == WDT_KEY_ON);
  wire wdt_key_bad  = (wdt_key != WDT_KEY_ON) && (wdt_key != WDT_KEY_OFF);
  wire rst_key_bad  = (rst_key != RST_KEY_A) && (rst_key != RST_KEY_B);
  wire key_fault    = wdt_key_bad | rst_key_bad;
  // sync phase plus two ticks gives the 1 to 2 cycle spread
  wire fault_fire   = key_fault && osc_tick && (fault_cnt == KEY_FAULT_TICKS - 2'h1);

  wire [CNT_W-1:0] limit = CNT_W'(1) << tsel_shift(tsel);
  wire overflow     = wdt_en && (wdt_cnt == limit);
  wire wdt_reset    = overflow && !low_power_i;
  wire wdt_wake     = overflow && low_power_i;
  wire full_reset   = wdt_reset | fault_fire;
  wire cnt_clear    = fault_fire | clear_watchdog_i | sleep_entry_i | overflow;

  wire wr_ctrl  = reg_wr_i && (reg_addr_i == WDT_CTRL_OFS);
  wire wr_flags = reg_wr_i && (reg_addr_i == RST_FLAGS_OFS);
  wire wr_key   = reg_wr_i && (reg_addr_i == RST_KEY_OFS);

  // software writes to flags, hardware set wins over a same-cycle clear
  wire [3:0] flag_set = {fault_fire & rst_key_bad, 2'b00, fault_fire & wdt_key_bad};
  wire [3:0] next_rst_flags = (wr_flags ? reg_wdata_i[3:0] : rst_flags) | flag_set;

  wire [7:0] status_val = {6'h00, power_down_flag, timeout_flag};
  wire [7:0] next_rdata =
    !reg_rd_i                        ? 8'h00 :
    (reg_addr_i == WDT_CTRL_OFS)     ? wdt_ctrl :
    (reg_addr_i == RST_FLAGS_OFS)    ? {4'h0, rst_flags} :
    (reg_addr_i == RST_KEY_OFS)      ? rst_key :
                                       status_val;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wdt_ctrl <= WDT_CTRL_RST;
      rst_key  <= RST_KEY_RST;
    end else if (fault_fire || wdt_reset) begin
      // a full reset reloads the keys so a bad code cannot loop
      wdt_ctrl <= WDT_CTRL_RST;
      rst_key  <= RST_KEY_RST;
    end else begin
      if (wr_ctrl) wdt_ctrl <= reg_wdata_i;
      if (wr_key)  rst_key  <= reg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rst_flags <= RST_FLAGS_RST;
    end else begin
      rst_flags <= next_rst_flags;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fault_cnt <= 2'h0;
    end else if (!key_fault || fault_fire) begin
      fault_cnt <= 2'h0;
    end else if (osc_tick) begin
      fault_cnt <= fault_cnt + 2'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || cnt_clear) begin
      wdt_cnt <= '0;
    end else if (wdt_en && osc_tick) begin
      wdt_cnt <= wdt_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      timeout_flag    <= 1'b0;
      power_down_flag <= 1'b0;
    end else begin
      if (overflow) begin
        timeout_flag <= 1'b1;
      end else if (sleep_entry_i) begin
        timeout_flag <= 1'b0;
      end
      if (sleep_entry_i) begin
        power_down_flag <= 1'b1;
      end else if (clear_watchdog_i) begin
        power_down_flag <= 1'b0;
      end
    end
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      device_reset_o <= 1'b0;
    end else begin
      device_reset_o <= full_reset;
    end
  end

  // held high through power-on so the core starts from zero
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pc_sp_clear_o <= 1'b1;
    end else begin
      pc_sp_clear_o <= full_reset | wdt_wake;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      port_preset_o <= 1'b1;
    end else begin
      port_preset_o <= full_reset;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wakeup_o <= 1'b0;
    end else begin
      wakeup_o <= wdt_wake;
    end
  end

endmodule // watchdog_and_reset_key_control
`default_nettype wire

// ---- wdt_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module wdt_chk
  import wdt_pkg::*;
(
  // clock, reset, register port
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // reset and wake outputs
  input wire logic       device_reset_o,
  input wire logic       pc_sp_clear_o,
  input wire logic       port_preset_o,
  input wire logic       wakeup_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire ok_en  = reg_wdata_i[WDT_KEY_MSB:WDT_KEY_LSB] inside {WDT_KEY_ON, WDT_KEY_OFF};
  wire bad_en = reg_wr_i && reg_addr_i == WDT_CTRL_OFS && !ok_en;
  wire bad_rk = reg_wr_i && reg_addr_i == RST_KEY_OFS && !(reg_wdata_i inside {RST_KEY_A, RST_KEY_B});
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data not idle");
  flag_hi_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == RST_FLAGS_OFS |-> reg_rdata_o[7:4] == 4'h0)
    else $error("flag upper bits set");
  rst_pulse_a: assert property (device_reset_o |=> !device_reset_o) else $error("reset not a pulse");
  preset_eq_a: assert property (!$past(sys_rst_i) |-> port_preset_o == device_reset_o)
    else $error("port preset mismatch");
  pcsp_eq_a: assert property (!$past(sys_rst_i) |-> pc_sp_clear_o == (device_reset_o || wakeup_o))
    else $error("pc clear mismatch");
  wake_pulse_a: assert property (wakeup_o |-> !device_reset_o ##1 !wakeup_o) else $error("bad wake pulse");
  key_fault_a: assert property (bad_en |-> !device_reset_o [*8] ##[1:32] device_reset_o)
    else $error("enable key fault timing");
  rkey_fault_a: assert property (bad_rk |-> !device_reset_o [*8] ##[1:32] device_reset_o)
    else $error("reset key fault timing");
  cover property (bad_en ##[1:40] device_reset_o);
  cover property (bad_rk ##[1:40] device_reset_o);
  cover property (wakeup_o);
endmodule // wdt_chk
bind watchdog_and_reset_key_control wdt_chk u_chk (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .device_reset_o, .pc_sp_clear_o, .port_preset_o, .wakeup_o);
`default_nettype wire

// ---- watchdog_and_reset_key_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_reset_key_control_tb_top
  import wdt_pkg::*;
;
  logic       mclk_i = 0, sys_rst_i = 1, low_speed_rc_osc_i = 0, clear_watchdog_i = 0;
  logic       sleep_entry_i = 0, low_power_i = 0;
  logic       reg_wr_i = 0, reg_rd_i = 0, device_reset_o, pc_sp_clear_o, port_preset_o, wakeup_o;
  logic [1:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o, d;
  int         err_total = 0, tests_run = 0, n, t;
  watchdog_and_reset_key_control dut (.mclk_i, .sys_rst_i, .low_speed_rc_osc_i, .clear_watchdog_i,
    .sleep_entry_i, .low_power_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .device_reset_o, .pc_sp_clear_o,
    .port_preset_o, .wakeup_o);
  initial forever #25 mclk_i = ~mclk_i;
  // fast slow-oscillator stand-in: one tick every 8 clocks
  initial forever begin
    repeat (4) @(posedge mclk_i);
    low_speed_rc_osc_i <= ~low_speed_rc_osc_i;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // extra idle edge keeps strobes from being reassigned in one step
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rc(input logic [1:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
    chk($sformatf("reg%0d", a), e, d);
    @(posedge mclk_i);
  endtask
  // e = {reset, wake}; 00 means no event may come within lim
  task automatic wt(input int lim, input logic [1:0] e);
    n = 0;
    while (pc_sp_clear_o !== 1'b1 && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    chk("event", {6'h00, e}, {6'h00, device_reset_o, wakeup_o});
    if (e != 2'b00 && n == lim) report_and_stop;
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    rc(WDT_CTRL_OFS, WDT_CTRL_RST);
    rc(RST_KEY_OFS, RST_KEY_RST);
    rc(WDT_STATUS_OFS, 8'h00);
    wr(RST_FLAGS_OFS, 8'hff);
    rc(RST_FLAGS_OFS, 8'h0f);
    wr(RST_FLAGS_OFS, 8'h00);
    wr(WDT_CTRL_OFS, 8'hf8);
    wt(60, 2'b10);
    rc(WDT_CTRL_OFS, WDT_CTRL_RST);
    rc(RST_FLAGS_OFS, 8'h01);
    wr(RST_KEY_OFS, 8'h12);
    wt(60, 2'b10);
    rc(RST_KEY_OFS, RST_KEY_RST);
    rc(RST_FLAGS_OFS, 8'h09);
    wr(RST_FLAGS_OFS, 8'h00);
    rc(RST_FLAGS_OFS, 8'h00);
    wr(RST_KEY_OFS, RST_KEY_B);
    wt(100, 2'b00);
    $display("test keys done");
    for (int c = 0; c < 3; c++) begin
      t = 8 << (8 + 2 * c);
      wr(WDT_CTRL_OFS, {WDT_KEY_ON, 3'(c)});
      clear_watchdog_i <= 1'b1;
      @(posedge mclk_i);
      clear_watchdog_i <= 1'b0;
      wt(t + 24, 2'b10);
      chk("early", 8'h00, {7'h00, n < t - 24});
    end
    rc(WDT_STATUS_OFS, 8'h01);
    $display("test timeout done");
    wr(WDT_CTRL_OFS, {WDT_KEY_ON, 3'h0});
    repeat (3) begin
      clear_watchdog_i <= 1'b1;
      @(posedge mclk_i);
      clear_watchdog_i <= 1'b0;
      wt(1500, 2'b00);
    end
    sleep_entry_i <= 1'b1;
    @(posedge mclk_i);
    sleep_entry_i <= 1'b0;
    rc(WDT_STATUS_OFS, 8'h02);
    low_power_i <= 1'b1;
    wt(2100, 2'b01);
    low_power_i <= 1'b0;
    rc(WDT_STATUS_OFS, 8'h03);
    $display("test sleep done");
    wr(WDT_CTRL_OFS, {WDT_KEY_OFF, 3'h0});
    wt(2500, 2'b00);
    rc(WDT_CTRL_OFS, 8'ha8);
    $display("test disable done");
    report_and_stop;
  end
endmodule // watchdog_and_reset_key_control_tb_top
`default_nettype wire
